/* rtl/bcr_regs.vh */
// Constants for the bank concurrency command checker
// Function
// - Rules only with CKE high twice, exit done
// - Deselect and NOP both continue current operation
// - Idle other bank never restricts bank m
// - Bank idle once precharged and tRP met
// - Row active once tRCD met, no burst
// - Read/write state holds until burst ends
// - Read AP splits at earliest precharge point
// - Write AP precharge starts when tWR ends
// - Burst terminate hits only the bursting bank
// - Reads/writes accepted with or without AP
// - Command codes on CS RAS CAS WE
`ifndef BCR_REGS_VH
`define BCR_REGS_VH
`define BCR_CMD_NOP    4'h7
`define BCR_CMD_ACT    4'h3
`define BCR_CMD_RD     4'h5
`define BCR_CMD_WR     4'h4
`define BCR_CMD_PRE    4'h2
`define BCR_CMD_BST    4'h6
`define BCR_CMD_REF    4'h1
`define BCR_CMD_MRS    4'h0
`define BCR_TCK_PS     4000
`define BCR_TRP_NS     15
`define BCR_TRCD_NS    15
`define BCR_TWR_NS     15
`define BCR_TXSR_NS    120
`define BCR_TRFC_NS    72
`define BCR_TMRD_CYC   2
`define BCR_CYC(ns)    (((ns) * 1000 + `BCR_TCK_PS - 1) / `BCR_TCK_PS)
`define BCR_TRP_CYC    `BCR_CYC(`BCR_TRP_NS)
`define BCR_TRCD_CYC   `BCR_CYC(`BCR_TRCD_NS)
`define BCR_TWR_CYC    `BCR_CYC(`BCR_TWR_NS)
`define BCR_TXSR_CYC   `BCR_CYC(`BCR_TXSR_NS)
`define BCR_TRFC_CYC   `BCR_CYC(`BCR_TRFC_NS)
`define BCR_BL_DFLT    4
`define BCR_WL_CYC     1
`endif

/* rtl/bcr_bank_fsm.v */
// Per-bank state tracker with its own period timer
`timescale 1ns/1ns
`default_nettype none
`include "bcr_regs.vh"
module bcr_bank_fsm #(
   parameter BURST_CYC = 2,
   parameter TRCD_CYC  = 4,
   parameter TRP_CYC   = 4,
   parameter TWR_CYC   = 4,
   parameter WL_CYC    = 1
) (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // Accepted commands for this bank
   input  wire       act,
   input  wire       rd,
   input  wire       wr,
   input  wire       pre,
   input  wire       bst,
   input  wire       auto_precharge_option,
   // State
   output wire [3:0] state,
   output wire       is_idle,
   output wire       is_open,
   output wire       is_read,
   output wire       is_burst,
   output wire       in_access
);
   localparam [3:0] S_IDLE = 4'h0, S_ACTV = 4'h1, S_ROW = 4'h2, S_RD = 4'h3, S_WR = 4'h4,
                    S_RDA = 4'h5, S_WRA = 4'h6, S_APPRE = 4'h7, S_PRE = 4'h8;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [6:0] tmr_q;
   reg [6:0] tmr_d;
   wire      expire;

   assign expire    = (tmr_q == 7'h01);
   assign state     = state_q;
   assign is_idle   = (state_q == S_IDLE);
   assign is_open   = (state_q == S_ROW) || (state_q == S_RD) || (state_q == S_WR);
   assign is_read   = (state_q == S_RD);
   assign is_burst  = (state_q == S_RD) || (state_q == S_WR);
   assign in_access = (state_q == S_RDA) || (state_q == S_WRA);

   always @* begin
      state_d = state_q;
      tmr_d   = (tmr_q != 7'h00) ? tmr_q - 7'h01 : 7'h00;
      if (act) begin
         state_d = S_ACTV;
         tmr_d   = TRCD_CYC[6:0];
      end else if (rd) begin
         // A new read truncates any burst still running
         state_d = auto_precharge_option ? S_RDA : S_RD;
         tmr_d   = BURST_CYC[6:0];
      end else if (wr) begin
         state_d = auto_precharge_option ? S_WRA : S_WR;
         tmr_d   = auto_precharge_option ? (WL_CYC[6:0] + BURST_CYC[6:0] + TWR_CYC[6:0])
                                         : (WL_CYC[6:0] + BURST_CYC[6:0]);
      end else if (pre) begin
         if (state_q != S_IDLE) begin
            state_d = S_PRE;
            tmr_d   = TRP_CYC[6:0];
         end
      end else if (bst && is_burst) begin
         state_d = S_ROW;
         tmr_d   = 7'h00;
      end else if (expire) begin
         case (state_q)
            S_ACTV:          state_d = S_ROW;
            S_RD, S_WR:      state_d = S_ROW;
            S_RDA, S_WRA: begin
               state_d = S_APPRE;
               tmr_d   = TRP_CYC[6:0];
            end
            S_APPRE, S_PRE:  state_d = S_IDLE;
            default:         state_d = state_q;
         endcase
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         tmr_q   <= 7'h00;
      end else begin
         state_q <= state_d;
         tmr_q   <= tmr_d;
      end
   end
endmodule // bcr_bank_fsm
`default_nettype wire

/* rtl/bcr_bank_rules.v */
// Command decoder that enforces the cross-bank command rules on four banks
`timescale 1ns/1ns
`default_nettype none
`include "bcr_regs.vh"
module bcr_bank_rules #(
   parameter NBANK     = 4,
   parameter BL        = `BCR_BL_DFLT,
   parameter TRCD_CYC  = `BCR_TRCD_CYC,
   parameter TRP_CYC   = `BCR_TRP_CYC,
   parameter TWR_CYC   = `BCR_TWR_CYC,
   parameter TXSR_CYC  = `BCR_TXSR_CYC,
   parameter TRFC_CYC  = `BCR_TRFC_CYC,
   parameter TMRD_CYC  = `BCR_TMRD_CYC
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Command pins
   input  wire             cke,
   input  wire             cs_n,
   input  wire             ras_n,
   input  wire             cas_n,
   input  wire             we_n,
   input  wire [1:0]       ba,
   input  wire             auto_precharge_option,
   // Status
   output reg              cmd_taken_q,
   output reg              cmd_illegal_q,
   output reg              rules_active_q,
   output wire [4*NBANK-1:0] bank_state
);
   localparam [2:0] K_NOP = 3'h0, K_ACT = 3'h1, K_RD = 3'h2, K_WR = 3'h3,
                    K_PRE = 3'h4, K_BST = 3'h5, K_REF = 3'h6, K_MRS = 3'h7;
   localparam BURST_CYC = BL / 2;

   function [2:0] cmd_kind;
      input       csn;
      input [2:0] rcw;
      begin
         if (csn) begin
            cmd_kind = K_NOP;
         end else begin
            case ({1'b0, rcw})
               `BCR_CMD_ACT: cmd_kind = K_ACT;
               `BCR_CMD_RD:  cmd_kind = K_RD;
               `BCR_CMD_WR:  cmd_kind = K_WR;
               `BCR_CMD_PRE: cmd_kind = K_PRE;
               `BCR_CMD_BST: cmd_kind = K_BST;
               `BCR_CMD_REF: cmd_kind = K_REF;
               `BCR_CMD_MRS: cmd_kind = K_MRS;
               default:      cmd_kind = K_NOP;
            endcase
         end
      end
   endfunction

   // Two-stage synchronisers for all pin inputs
   reg  [7:0] pin_s1_q;
   reg  [7:0] pin_s2_q;
   wire       cke_s;
   wire       csn_s;
   wire [2:0] rcw_s;
   wire [1:0] ba_s;
   wire       ap_s;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Reset to deselect with cke low, so no command is seen after reset
         pin_s1_q <= 8'h78;
         pin_s2_q <= 8'h78;
      end else begin
         pin_s1_q <= {cke, cs_n, ras_n, cas_n, we_n, ba, auto_precharge_option};
         pin_s2_q <= pin_s1_q;
      end
   end
   assign cke_s = pin_s2_q[7];
   assign csn_s = pin_s2_q[6];
   assign rcw_s = pin_s2_q[5:3];
   assign ba_s  = pin_s2_q[2:1];
   assign ap_s  = pin_s2_q[0];

   // Clock enable history and exit timer
   reg        cke_prev_q;
   reg  [7:0] exit_q;
   reg  [7:0] busy_q;
   wire [2:0] kind;
   wire       rules_on;

   assign kind     = cmd_kind(csn_s, rcw_s);
   assign rules_on = cke_s && cke_prev_q && (exit_q == 8'h00);

   // Bank tracker outputs
   wire [NBANK-1:0] b_idle;
   wire [NBANK-1:0] b_open;
   wire [NBANK-1:0] b_read;
   wire [NBANK-1:0] b_burst;
   wire [NBANK-1:0] b_access;
   wire [NBANK-1:0] sel;
   wire [NBANK-1:0] others;
   reg              legal;
   wire             go;

   genvar g;
   generate
      for (g = 0; g < NBANK; g = g + 1) begin : g_bank
         localparam [1:0] BIDX = g;
         assign sel[g] = (ba_s == BIDX);
         bcr_bank_fsm #(
            .BURST_CYC (BURST_CYC),
            .TRCD_CYC  (TRCD_CYC),
            .TRP_CYC   (TRP_CYC),
            .TWR_CYC   (TWR_CYC),
            .WL_CYC    (`BCR_WL_CYC)
         ) u_bank (
            .clk                   (clk),
            .rst_n                 (rst_n),
            .act                   (go && (kind == K_ACT) && sel[g]),
            .rd                    (go && (kind == K_RD) && sel[g]),
            .wr                    (go && (kind == K_WR) && sel[g]),
            .pre                   (go && (kind == K_PRE) && (sel[g] || ap_s)),
            .bst                   (go && (kind == K_BST) && sel[g]),
            .auto_precharge_option (ap_s),
            .state                 (bank_state[4*g+3:4*g]),
            .is_idle               (b_idle[g]),
            .is_open               (b_open[g]),
            .is_read               (b_read[g]),
            .is_burst              (b_burst[g]),
            .in_access             (b_access[g])
         );
      end
   endgenerate

   assign others = ~sel;

   // Idle banks in the other set never veto; REF and MRS need all banks idle, else only access-period or read banks do
   always @* begin
      legal = 1'b0;
      case (kind)
         K_ACT: legal = |(b_idle & sel);
         K_RD:  legal = |(b_open & sel) && !(|(b_access & others));
         K_WR:  legal = |(b_open & sel) && !(|(b_access & others))
                        && !(|(b_read & others));
         K_PRE: legal = ap_s ? !(|b_access) : !(|(b_access & sel));
         K_BST: legal = |(b_burst & sel);
         K_REF: legal = &b_idle;
         K_MRS: legal = &b_idle;
         default: legal = 1'b1;
      endcase
   end

   // Illegal or reserved commands are dropped so the trackers stay consistent
   assign go = rules_on && (busy_q == 8'h00) && (kind != K_NOP) && legal;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cke_prev_q     <= 1'b0;
         exit_q         <= 8'h00;
         busy_q         <= 8'h00;
         cmd_taken_q    <= 1'b0;
         cmd_illegal_q  <= 1'b0;
         rules_active_q <= 1'b0;
      end else begin
         cke_prev_q <= cke_s;
         if (!cke_s) begin
            exit_q <= TXSR_CYC[7:0];
         end else if (exit_q != 8'h00) begin
            exit_q <= exit_q - 8'h01;
         end
         if (go && (kind == K_REF)) begin
            busy_q <= TRFC_CYC[7:0];
         end else if (go && (kind == K_MRS)) begin
            busy_q <= TMRD_CYC[7:0];
         end else if (busy_q != 8'h00) begin
            busy_q <= busy_q - 8'h01;
         end
         cmd_taken_q    <= go;
         cmd_illegal_q  <= cke_s && cke_prev_q && (kind != K_NOP) && !go;
         rules_active_q <= rules_on;
      end
   end
endmodule // bcr_bank_rules
`default_nettype wire

/* rtl/README_unused.v */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* sim/bcr_rules_monitor.sv */
// Checker for the cross-bank command decoder
`timescale 1ns/1ns
`default_nettype none
module bcr_rules_mon #(parameter NBANK = 4) (
   // Clock, reset and command pins
   input wire                clk, rst_n, cke, cs_n, ras_n, cas_n, we_n,
   input wire [1:0]          ba,
   input wire                auto_precharge_option,
   // Status
   input wire                cmd_taken_q, cmd_illegal_q, rules_active_q,
   input wire [4*NBANK-1:0]  bank_state
);
   wire [3:0] b0  = bank_state[3:0];
   wire [3:0] pin = {cs_n, ras_n, cas_n, we_n};
   wire       ap  = auto_precharge_option;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_nop_quiet: assert property ((pin[3] || pin == 4'h7) |-> ##3 !cmd_taken_q && !cmd_illegal_q)
      else $error("Answer to a no-op");
   a_cke_gate: assert property (!cke |-> ##3 !cmd_taken_q)
      else $error("Command taken with clock enable low");
   a_rules_cke: assert property (rules_active_q |-> $past(cke, 3))
      else $error("Rules active without clock enable");
   a_refuse_src: assert property (cmd_illegal_q |-> $past(cs_n, 3) == 1'b0)
      else $error("Refusal without a command");
   a_act_opens: assert property ((pin == 4'h3 && ba == 2'h0) ##3 cmd_taken_q |-> b0 == 4'h1)
      else $error("Activate did not start activating");
   a_row_ready: assert property ($rose(b0 == 4'h2) && $past(b0) == 4'h1 |-> $past(b0, 3) == 4'h1)
      else $error("Row active too early");
   a_rd_holds: assert property ((pin == 4'h5 && ba == 2'h0 && !ap) ##3 cmd_taken_q |-> b0 == 4'h3)
      else $error("Read state not entered");
   a_wr_auto: assert property ((pin == 4'h4 && ba == 2'h0 && ap) ##3 cmd_taken_q |-> b0 == 4'h6)
      else $error("Auto-precharge write access not entered");
   a_ap_split: assert property ($rose(b0 == 4'h7) |-> $past(b0) == 4'h5 || $past(b0) == 4'h6)
      else $error("Precharge period without access period");
   a_idle_pre: assert property ($rose(b0 == 4'h0) |-> $past(b0) == 4'h7 || $past(b0) == 4'h8)
      else $error("Idle reached without precharge");
endmodule // bcr_rules_mon
bind bcr_bank_rules bcr_rules_mon #(.NBANK(NBANK)) mon_u (.clk(clk), .rst_n(rst_n), .cke(cke),
   .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
   .auto_precharge_option(auto_precharge_option), .cmd_taken_q(cmd_taken_q),
   .cmd_illegal_q(cmd_illegal_q), .rules_active_q(rules_active_q), .bank_state(bank_state));
`default_nettype wire

/* sim/bcr_ctl_model.sv */
// Controller-side pin driver for the command decoder
`timescale 1ns/1ns
`default_nettype none
module bcr_ctl_model (
   // Clock and request
   input wire        clk,
   input wire [3:0]  cmd,
   input wire [1:0]  bank,
   input wire        ap,
   // Command pins
   output wire       cs_n, ras_n, cas_n, we_n,
   output wire [1:0] ba,
   output wire       apo
);
   reg [2:0] junk_q = 3'h0;
   // Deselected cycles show a moving pattern so no held value can pass as a command
   always @(posedge clk) junk_q <= junk_q + 3'h3;
   // No data bus here, so masking and data collisions stay with the caller
   assign cs_n = cmd[3];
   assign {ras_n, cas_n, we_n} = cmd[3] ? junk_q : cmd[2:0];
   assign ba  = cmd[3] ? junk_q[1:0] : bank;
   assign apo = cmd[3] ? junk_q[2] : ap;
endmodule // bcr_ctl_model
`default_nettype wire

/* sim/tb.sv */
// Testbench for the cross-bank command decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
   reg        clk = 1'b0, rst_n = 1'b0, cke = 1'b1, ap = 1'b0;
   reg  [3:0] cmd = 4'h7;
   reg  [1:0] bank = 2'h0;
   wire       cs_n, ras_n, cas_n, we_n, apo, taken, illeg, active;
   wire [1:0] ba;
   wire [15:0] bank_state;
   integer    fail_count = 0, checks_done = 0, n_tk = 0, n_il = 0, t0, i0, i;
   bcr_ctl_model ctl_u (.clk(clk), .cmd(cmd), .bank(bank), .ap(ap), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .apo(apo));
   bcr_bank_rules #(.TXSR_CYC(3), .TRFC_CYC(3)) dut_u (.clk(clk), .rst_n(rst_n), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .auto_precharge_option(apo), .cmd_taken_q(taken), .cmd_illegal_q(illeg),
      .rules_active_q(active), .bank_state(bank_state));
   initial forever #2 clk = ~clk;
   // Count on the falling edge so each one-cycle pulse is seen exactly once
   always @(negedge clk) begin
      if (taken === 1'b1) n_tk = n_tk + 1;
      if (illeg === 1'b1) n_il = n_il + 1;
   end
   task stop_test;
      begin
         if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task go(input [3:0] c, input [1:0] b, input a);
      begin
         @(posedge clk);
         cmd <= c;
         bank <= b;
         ap <= a;
      end
   endtask
   task quiet(input integer n);
      begin
         go(4'h7, 2'h0, 1'b0);
         repeat (n - 1) @(posedge clk);
      end
   endtask
   task mark;
      begin
         t0 = n_tk;
         i0 = n_il;
      end
   endtask
   task wait_active;
      begin
         i = 0;
         while (active !== 1'b1 && i < 200) begin
            @(posedge clk);
            i = i + 1;
         end
         if (i == 200) begin
            fail_count = fail_count + 1;
            stop_test;
         end
      end
   endtask
   task t_open;
      begin
         mark;
         go(4'h3, 2'h0, 1'b0);
         go(4'h3, 2'h1, 1'b0);
         go(4'h3, 2'h0, 1'b0);
         go(4'h8, 2'h0, 1'b0);
         quiet(10);
         chk(n_tk - t0, 16'h2);
         chk(n_il - i0, 16'h1);
         chk(bank_state, 16'h0022);
      end
   endtask
   task t_cross;
      begin
         mark;
         go(4'h5, 2'h0, 1'b0);
         quiet(1);
         go(4'h4, 2'h1, 1'b0);
         go(4'h6, 2'h1, 1'b0);
         quiet(4);
         go(4'h5, 2'h0, 1'b0);
         quiet(1);
         go(4'h6, 2'h0, 1'b0);
         quiet(8);
         chk(n_tk - t0, 16'h3);
         chk(n_il - i0, 16'h2);
         chk(bank_state, 16'h0022);
      end
   endtask
   task t_ap;
      begin
         mark;
         go(4'h4, 2'h0, 1'b1);
         quiet(1);
         go(4'h5, 2'h1, 1'b0);
         go(4'h3, 2'h2, 1'b0);
         quiet(5);
         go(4'h5, 2'h1, 1'b0);
         quiet(12);
         chk(n_tk - t0, 16'h3);
         chk(n_il - i0, 16'h1);
         chk(bank_state, 16'h0220);
      end
   endtask
   task t_refresh;
      begin
         mark;
         go(4'h1, 2'h0, 1'b0);
         go(4'h2, 2'h0, 1'b1);
         quiet(8);
         chk(bank_state, 16'h0000);
         go(4'h1, 2'h0, 1'b0);
         quiet(8);
         go(4'h0, 2'h0, 1'b0);
         quiet(8);
         chk(n_tk - t0, 16'h3);
         chk(n_il - i0, 16'h1);
      end
   endtask
   task t_cke;
      begin
         mark;
         @(posedge clk);
         cke <= 1'b0;
         repeat (4) @(posedge clk);
         chk(active, 1'b0);
         cke <= 1'b1;
         go(4'h3, 2'h3, 1'b0);
         quiet(6);
         chk(n_tk - t0, 16'h0);
         wait_active;
         go(4'h3, 2'h3, 1'b0);
         quiet(8);
         chk(n_tk - t0, 16'h1);
         chk(bank_state[15:12], 4'h2);
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wait_active;
      chk(bank_state, 16'h0000);
      t_open;
      t_cross;
      t_ap;
      t_refresh;
      t_cke;
      stop_test;
   end
endmodule // tb
`default_nettype wire
